// ==== src/psr_pkg.sv ====
/*
 * Constants shared by the parallel-load shift register block: stage count,
 * APB register map, field positions, reset values and buffer sizes.
 * Assumes a 32-bit APB master and a single 100 MHz core clock.
 */
// Functional notes
// - Eight stages A to H; stage H drives the serial output.
// - Clear low forces all stages to zero, overriding every other input.
// - Select high: each edge shifts serial input into A, stages move toward H.
// - Select low: next edge copies parallel inputs a..h into stages A..H together.
// - During parallel load the serial input enters no stage.
// - Internal clock is NOR of clock and inhibit; update on its rising edge (code delays it while capture is on and buffer full; a further edge is lost).
// - Either input held high blocks edges; one held low lets the other clock.
// - Without a qualifying rising edge all stages keep their values.
package psr_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned PSR_STAGES = 8;
  localparam int unsigned PSR_FIFO_DEPTH = 16;
  localparam int unsigned PSR_LVL_W = $clog2(PSR_FIFO_DEPTH + 1);

  // ****************************************************************
  // APB register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] PSR_CTRL_ADDR = 8'h00;
  localparam logic [7:0] PSR_STAT_ADDR = 8'h04;
  localparam logic [7:0] PSR_DATA_ADDR = 8'h08;

  // Control fields
  localparam int unsigned PSR_CTRL_CAPEN_BIT = 0;
  localparam int unsigned PSR_CTRL_SWCLR_BIT = 1;
  localparam logic [1:0] PSR_CTRL_RESET = 2'h0;

  // Status fields
  localparam int unsigned PSR_STAT_STAGE_LSB = 0;
  localparam int unsigned PSR_STAT_SOUT_BIT = 8;
  localparam int unsigned PSR_STAT_OVR_BIT = 9;
  localparam int unsigned PSR_STAT_EMPTY_BIT = 10;
  localparam int unsigned PSR_STAT_FULL_BIT = 11;
  localparam int unsigned PSR_STAT_LVL_LSB = 16;

  // Data register fields
  localparam int unsigned PSR_DATA_VALID_BIT = 31;

  localparam logic [PSR_STAGES-1:0] PSR_STAGE_RESET = 8'h00;
  localparam logic [31:0] PSR_WORD_ZERO = 32'h0000_0000;

endpackage

// ==== src/psr_fifo_if.sv ====
/*
 * Carrier between the shift register core and its snapshot buffer:
 * a valid/ready push side and a valid/ready pop side plus fill level.
 * Assumes both ends share the core clock.
 */
interface psr_fifo_if #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned LVL_W = 5
);
  logic [WIDTH-1:0] push_data;
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] pop_data;
  logic pop_valid;
  logic pop_ready;
  logic [LVL_W-1:0] level;

  modport buf_side (
    input push_data,
    input push_valid,
    output push_ready,
    output pop_data,
    output pop_valid,
    input pop_ready,
    output level
  );

  modport user_side (
    output push_data,
    output push_valid,
    input push_ready,
    input pop_data,
    input pop_valid,
    output pop_ready,
    input level
  );
endinterface

// ==== src/psr_fifo.sv ====
/*
 * Synchronous FIFO with parameters for width and depth, valid/ready on
 * both sides and honest full/empty through the ready/valid flags.
 * Assumes depth is a power of two and one clock for both sides.
 */
module psr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  psr_fifo_if.buf_side f
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  // Full and empty come straight from the occupancy count
  assign f.push_ready = (cnt_q != (AW+1)'(DEPTH));
  assign f.pop_valid = (cnt_q != '0);
  assign f.pop_data = mem[rd_ptr_q];
  assign f.level = cnt_q;
  assign do_push = ce_i && f.push_valid && f.push_ready;
  assign do_pop = ce_i && f.pop_valid && f.pop_ready;

  // Storage is not reset; only the pointers and count define what is valid
  always_ff @(posedge core_clk_i)
  begin
    if (do_push)
    begin
      mem[wr_ptr_q] <= f.push_data;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (do_pop)
      begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      if (do_push && !do_pop)
      begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end
      else if (do_pop && !do_push)
      begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end
endmodule

// ==== src/psr_top.sv ====
/*
 * Eight-stage parallel-load shift register with gated pin clock, plus an
 * APB slave for control, status and a buffer of stage snapshots.
 * Assumes all pin inputs are synchronous to core_clk_i and a 32-bit APB master.
 */
module psr_top
  import psr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Device pins
  input wire logic clear_n_i,
  input wire logic shift_load_select_i,
  input wire logic shift_clock_i,
  input wire logic clock_inhibit_i,
  input wire logic serial_in_i,
  input wire logic [PSR_STAGES-1:0] parallel_i,
  output logic serial_out_o,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [PSR_STAGES-1:0] stage_q;
  logic [PSR_STAGES-1:0] stage_d;
  logic comb_clk;
  logic comb_clk_q;
  logic edge_pulse;
  logic pending_q;
  logic update_go;
  logic capture_en_q;
  logic sw_clear_q;
  logic overrun_q;
  logic push_q;
  logic [PSR_STAGES-1:0] push_data_q;
  logic apb_setup;
  logic apb_done;
  logic addr_hit;
  logic [31:0] rd_word;
  logic ovr_clr;
  logic pop_go;

  psr_fifo_if #(
    .WIDTH(PSR_STAGES),
    .LVL_W(PSR_LVL_W)
  ) fifo_bus ();

  // ****************************************************************
  // Gated pin clock
  // ****************************************************************

  // Combined clock is high only while both inputs are low
  assign comb_clk = ~(shift_clock_i | clock_inhibit_i);

  // Previous level of the combined clock, for edge detection
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      comb_clk_q <= 1'b1;
    end
    else if (ce_i)
    begin
      comb_clk_q <= comb_clk;
    end
  end

  // One pulse per low-to-high change; level holding gives no pulse
  assign edge_pulse = comb_clk && !comb_clk_q;

  // An edge waits here while the buffer cannot take its snapshot.
  // Trade-off: one edge can queue; a further edge meanwhile is lost and flagged.
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pending_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!clear_n_i || sw_clear_q)
      begin
        pending_q <= 1'b0;
      end
      else if (edge_pulse && !(pending_q && !update_go))
      begin
        pending_q <= !(!capture_en_q || fifo_bus.push_ready);
      end
      else if (update_go)
      begin
        pending_q <= 1'b0;
      end
    end
  end

  // Update happens on a fresh edge or a queued one, once the buffer has room or capture is off
  assign update_go = (edge_pulse || pending_q) &&
                     (!capture_en_q || fifo_bus.push_ready);

  // ****************************************************************
  // Shift register stages
  // ****************************************************************

  // Next stage value: stage 0 is A, stage 7 is H
  always_comb
  begin
    stage_d = stage_q;
    if (update_go)
    begin
      if (shift_load_select_i)
      begin
        stage_d = {stage_q[PSR_STAGES-2:0], serial_in_i};
      end
      else
      begin
        stage_d = parallel_i;
      end
    end
  end

  // Clear wins over any edge in the same cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stage_q <= PSR_STAGE_RESET;
    end
    else if (ce_i)
    begin
      if (!clear_n_i || sw_clear_q)
      begin
        stage_q <= PSR_STAGE_RESET;
      end
      else
      begin
        stage_q <= stage_d;
      end
    end
  end

  // Serial output is stage H, registered so it also tracks clear
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      serial_out_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!clear_n_i || sw_clear_q)
      begin
        serial_out_o <= 1'b0;
      end
      else
      begin
        serial_out_o <= stage_d[PSR_STAGES-1];
      end
    end
  end

  // ****************************************************************
  // Snapshot buffer
  // ****************************************************************

  // Each update pushes the new stage contents when capture is on
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      push_q <= 1'b0;
      push_data_q <= PSR_STAGE_RESET;
    end
    else if (ce_i)
    begin
      push_q <= update_go && capture_en_q && clear_n_i && !sw_clear_q;
      push_data_q <= stage_d;
    end
  end

  assign fifo_bus.push_valid = push_q;
  assign fifo_bus.push_data = push_data_q;
  assign fifo_bus.pop_ready = pop_go;

  psr_fifo #(
    .WIDTH(PSR_STAGES),
    .DEPTH(PSR_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .f(fifo_bus.buf_side)
  );

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // One wait state: read data is registered on the same edge that raises pready
  assign apb_setup = psel_i && penable_i && !pready_o;
  assign apb_done = psel_i && penable_i && pready_o;
  assign addr_hit = (paddr_i == PSR_CTRL_ADDR) || (paddr_i == PSR_STAT_ADDR) ||
                    (paddr_i == PSR_DATA_ADDR);

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_word = PSR_WORD_ZERO;
    unique case (paddr_i)
      PSR_CTRL_ADDR:
      begin
        rd_word[PSR_CTRL_CAPEN_BIT] = capture_en_q;
      end
      PSR_STAT_ADDR:
      begin
        rd_word[PSR_STAT_STAGE_LSB +: PSR_STAGES] = stage_q;
        rd_word[PSR_STAT_SOUT_BIT] = serial_out_o;
        rd_word[PSR_STAT_OVR_BIT] = overrun_q;
        rd_word[PSR_STAT_EMPTY_BIT] = !fifo_bus.pop_valid;
        rd_word[PSR_STAT_FULL_BIT] = !fifo_bus.push_ready;
        rd_word[PSR_STAT_LVL_LSB +: PSR_LVL_W] = fifo_bus.level;
      end
      PSR_DATA_ADDR:
      begin
        // Empty buffer reads zero data, so stale storage never leaks out
        rd_word[PSR_STAGES-1:0] = fifo_bus.pop_valid ? fifo_bus.pop_data : PSR_STAGE_RESET;
        rd_word[PSR_DATA_VALID_BIT] = fifo_bus.pop_valid;
      end
      default:
      begin
        rd_word = PSR_WORD_ZERO;
      end
    endcase
  end

  // A completed read of the data register pops one snapshot
  assign pop_go = apb_done && !pwrite_i && (paddr_i == PSR_DATA_ADDR) &&
                  fifo_bus.pop_valid;
  assign ovr_clr = apb_done && pwrite_i && (paddr_i == PSR_STAT_ADDR) &&
                   pwdata_i[PSR_STAT_OVR_BIT];

  // Handshake and answer registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= PSR_WORD_ZERO;
    end
    else if (ce_i)
    begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup && !addr_hit;
      if (apb_setup && !pwrite_i)
      begin
        prdata_o <= rd_word;
      end
    end
  end

  // Control register; the soft clear bit self-clears after one cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      capture_en_q <= PSR_CTRL_RESET[PSR_CTRL_CAPEN_BIT];
      sw_clear_q <= PSR_CTRL_RESET[PSR_CTRL_SWCLR_BIT];
    end
    else if (ce_i)
    begin
      sw_clear_q <= 1'b0;
      if (apb_done && pwrite_i && (paddr_i == PSR_CTRL_ADDR))
      begin
        capture_en_q <= pwdata_i[PSR_CTRL_CAPEN_BIT];
        sw_clear_q <= pwdata_i[PSR_CTRL_SWCLR_BIT];
      end
    end
  end

  // Sticky overrun: a lost edge sets it, and setting wins over the clear
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      overrun_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (edge_pulse && pending_q && !update_go && clear_n_i)
      begin
        overrun_q <= 1'b1;
      end
      else if (ovr_clr)
      begin
        overrun_q <= 1'b0;
      end
    end
  end

endmodule

// ==== tb/psr_properties.sv ====
/*
 * Checker for psr_top: pin-side stage behaviour and APB handshake timing.
 * Sees only the top ports; assumes capture never meets a full buffer.
 */
module psr_checker
  import psr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic clear_n_i,
  input wire logic shift_load_select_i,
  input wire logic shift_clock_i,
  input wire logic clock_inhibit_i,
  input wire logic serial_in_i,
  input wire logic [PSR_STAGES-1:0] parallel_i,
  input wire logic serial_out_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Shadow of the combined clock and the stages
  // ****************************************************************
  logic comb_q;
  logic [7:0] shadow_q;
  logic rise;
  assign rise = ce_i && !(shift_clock_i || clock_inhibit_i) && !comb_q;
  // History starts high so a low pin clock at release is no edge
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
    if (sys_rst_i) comb_q <= 1'b1;
    else if (ce_i) comb_q <= !(shift_clock_i || clock_inhibit_i);
  // Clear wins over an edge in the same cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
    if (sys_rst_i) shadow_q <= 8'h00;
    else if (ce_i && !clear_n_i) shadow_q <= 8'h00;
    else if (rise && shift_load_select_i) shadow_q <= {shadow_q[6:0], serial_in_i};
    else if (rise) shadow_q <= parallel_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence apb_setup;
    psel_i && !penable_i && ce_i;
  endsequence
  sequence apb_access;
    psel_i && penable_i && ce_i;
  endsequence
  // Exact stage model: any slip in shift, load or clear shows at stage H
  serial_tie_a: assert property (serial_out_o == shadow_q[7])
    else $error("serial out differs from last stage");
  clear_zero_a: assert property (ce_i && !clear_n_i |=> !serial_out_o)
    else $error("clear did not zero the stages");
  shift_move_a: assert property (rise && clear_n_i && shift_load_select_i |=>
    serial_out_o == $past(shadow_q[6])) else $error("shift did not move stages");
  load_copy_a: assert property (rise && clear_n_i && !shift_load_select_i |=>
    serial_out_o == $past(parallel_i[7])) else $error("load did not copy inputs");
  inhibit_block_a: assert property ((shift_clock_i || clock_inhibit_i) && clear_n_i |=>
    $stable(serial_out_o)) else $error("stages moved while clocking was blocked");
  single_update_a: assert property (!rise && clear_n_i |=> $stable(serial_out_o))
    else $error("stages moved without a combined clock edge");
  apb_wait_a: assert property (apb_setup ##1 apb_access |=> pready_o)
    else $error("ready not given one cycle into access");
  apb_early_a: assert property (apb_setup |=> !pready_o)
    else $error("ready given in setup");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  ready_pulse_a: assert property (pready_o && ce_i |=> !pready_o)
    else $error("ready held longer than one cycle");
endmodule

bind psr_top psr_checker chk (.core_clk_i, .sys_rst_i, .ce_i, .clear_n_i,
  .shift_load_select_i, .shift_clock_i, .clock_inhibit_i, .serial_in_i, .parallel_i,
  .serial_out_o, .psel_i, .penable_i, .pready_o, .pslverr_o);

// ==== tb/psr_pin_ctl.sv ====
/*
 * Controller model on the pin side: drives clear, select, clock, inhibit
 * and data pins from tasks, always just after a rising core clock edge.
 */
module psr_pin_ctl (
  input wire logic core_clk_i,
  output logic clear_n_o,
  output logic sel_o,
  output logic clk_o,
  output logic inh_o,
  output logic ser_o,
  output logic [7:0] par_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clear held from time zero since stage contents start undefined
  initial
  begin
    clear_n_o = 1'b0;
    sel_o = 1'b1;
    clk_o = 1'b1;
    inh_o = 1'b0;
    ser_o = 1'b0;
    par_o = 8'h00;
  end
  task automatic release_clear();
    @(posedge core_clk_i);
    clear_n_o <= 1'b1;
  endtask
  // One low pulse of the pin clock gives one combined clock rise
  task automatic step(input logic s, input logic d, input logic [7:0] p);
    @(posedge core_clk_i);
    sel_o <= s;
    ser_o <= d;
    par_o <= p;
    clk_o <= 1'b0;
    @(posedge core_clk_i);
    clk_o <= 1'b1;
    @(posedge core_clk_i);
  endtask
  // Inhibit rises while the clock is high; the one edge comes when inhibit falls with the clock low
  task automatic pause_edge(input logic d);
    @(posedge core_clk_i);
    inh_o <= 1'b1;
    sel_o <= 1'b1;
    ser_o <= d;
    repeat (4)
    begin
      @(posedge core_clk_i);
      clk_o <= !clk_o;
    end
    @(posedge core_clk_i);
    clk_o <= 1'b0;
    @(posedge core_clk_i);
    inh_o <= 1'b0;
    @(posedge core_clk_i);
    clk_o <= 1'b1;
    @(posedge core_clk_i);
  endtask
  // Clear and a clock edge land in the same cycle
  task automatic clear_edge();
    @(posedge core_clk_i);
    clear_n_o <= 1'b0;
    clk_o <= 1'b0;
    @(posedge core_clk_i);
    clear_n_o <= 1'b1;
    clk_o <= 1'b1;
    @(posedge core_clk_i);
  endtask
endmodule

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for psr_top: pin scenarios through psr_pin_ctl,
 * registers through an APB master task. Clock enable stays high.
 */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import psr_pkg::*;
  logic core_clk_i, sys_rst_i, ce_i, clear_n_i, shift_load_select_i, shift_clock_i;
  logic clock_inhibit_i, serial_in_i, serial_out_o, psel_i, penable_i, pwrite_i;
  logic pready_o, pslverr_o, err;
  logic [7:0] parallel_i, paddr_i, stg;
  logic [31:0] pwdata_i, prdata_o, rd;
  int n_fail = 0;
  int check_count = 0;
  psr_top dut (.core_clk_i, .sys_rst_i, .ce_i, .clear_n_i, .shift_load_select_i,
    .shift_clock_i, .clock_inhibit_i, .serial_in_i, .parallel_i, .serial_out_o,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
  psr_pin_ctl pins (.core_clk_i, .clear_n_o(clear_n_i), .sel_o(shift_load_select_i),
    .clk_o(shift_clock_i), .inh_o(clock_inhibit_i), .ser_o(serial_in_i), .par_o(parallel_i));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until ready is sampled high at a rising edge; released only after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_fail++;
      finish_test();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Expected status word from stages and buffer level
  function automatic logic [31:0] st(input logic [7:0] s, input int l);
    st = {11'h000, 5'(l), 4'h0, l == 16, l == 0, 1'b0, s[7], s};
  endfunction
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_reset();
    chk("serial out", 32'(serial_out_o), 32'h0);
    apb(1'b0, PSR_STAT_ADDR, 32'h0);
    chk("status", rd, st(8'h00, 0));
    apb(1'b0, PSR_CTRL_ADDR, 32'h0);
    chk("control", rd, 32'h0);
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    chk("unmapped err", 32'(err), 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped data", rd, 32'h0);
  endtask
  task automatic s_load();
    pins.step(1'b0, 1'b1, 8'h96);
    stg = 8'h96;
    chk("serial out", 32'(serial_out_o), 32'h1);
    apb(1'b0, PSR_STAT_ADDR, 32'h0);
    chk("status", rd, st(stg, 0));
  endtask
  task automatic s_shift();
    for (int i = 0; i < 8; i++)
    begin
      pins.step(1'b1, 1'(8'h35 >> i), 8'hff);
      stg = {stg[6:0], 1'(8'h35 >> i)};
      chk("serial out", 32'(serial_out_o), 32'(stg[7]));
    end
    apb(1'b0, PSR_STAT_ADDR, 32'h0);
    chk("status", rd, st(stg, 0));
  endtask
  // Output fed back to the serial input, as a second chained stage would see it
  task automatic s_chain();
    for (int i = 0; i < 8; i++)
    begin
      pins.step(1'b1, serial_out_o, 8'h00);
      stg = {stg[6:0], stg[7]};
      chk("chained out", 32'(serial_out_o), 32'(stg[7]));
    end
  endtask
  task automatic s_pause();
    pins.pause_edge(1'b1);
    stg = {stg[6:0], 1'b1};
    apb(1'b0, PSR_STAT_ADDR, 32'h0);
    chk("status", rd, st(stg, 0));
  endtask
  task automatic s_clear();
    pins.clear_edge();
    chk("serial out", 32'(serial_out_o), 32'h0);
    apb(1'b0, PSR_STAT_ADDR, 32'h0);
    chk("status", rd, st(8'h00, 0));
  endtask
  // Fill the snapshot buffer to full with no reader, then drain it
  task automatic s_fifo();
    apb(1'b1, PSR_CTRL_ADDR, 32'h1);
    for (int i = 1; i <= 16; i++)
      pins.step(1'b0, 1'b0, 8'(i));
    apb(1'b0, PSR_STAT_ADDR, 32'h0);
    chk("status full", rd, st(8'h10, 16));
    for (int i = 1; i <= 16; i++)
    begin
      apb(1'b0, PSR_DATA_ADDR, 32'h0);
      chk("snapshot", rd, {1'b1, 23'h0, 8'(i)});
    end
    apb(1'b0, PSR_DATA_ADDR, 32'h0);
    chk("empty data", rd, 32'h0);
    apb(1'b0, PSR_STAT_ADDR, 32'h0);
    chk("status empty", rd, st(8'h10, 0));
  endtask
  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    finish_test();
  end
  initial
  begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    pins.release_clear();
    s_reset();
    s_load();
    s_shift();
    s_pause();
    s_chain();
    s_clear();
    s_fifo();
    finish_test();
  end
endmodule
